//--- logic/splk_pkg.sv
// Contract
// - first of three address bytes picks the sector
// - after address, output bit every clock
// - repeated FFh if protected, 00h otherwise
// - chip select release ends read, output off
// - release mid-byte is accepted cleanly
// - summary reports all, some, none protected
// - readout ignores write-protect pin level
// - hardware lock: pin asserted and lock set
// - hardware lock freezes bits, ignores writes
// - clearing lock performs no global action
// - pin held low: only power-up clears lock
// - pin released: lock may still be set
// - setting lock may also do global action
// - lock clear: all protect operations allowed
// - soft lock: status write may clear lock
// - locked: no global, no sector commands
// - only bit 7 stored; bits 5:2 decoded
// - 7Fh protects, 00h unprotects, FFh both
package splk_pkg;

  localparam int SECTORS = 32;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BYTES = 3;
  // index of the address byte that carries the sector number
  localparam logic [1:0] SECTOR_BYTE = 2'h0;
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [7:0] OP_READ_PROT = 8'h3c;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;

  localparam int LOCK_POS = 7;
  localparam int GLOBAL_HI = 5;
  localparam int GLOBAL_LO = 2;
  localparam logic [3:0] GLOBAL_SET = 4'hf;
  localparam logic [3:0] GLOBAL_CLEAR = 4'h0;

  localparam logic [1:0] SUMMARY_NONE = 2'h0;
  localparam logic [1:0] SUMMARY_SOME = 2'h1;
  localparam logic [1:0] SUMMARY_ALL = 2'h3;

  localparam logic LOCK_RST = 1'h0;
  localparam logic PROT_RST = 1'h1;
  localparam logic WP_RST = 1'h1;

endpackage : splk_pkg

//--- logic/splk_sector_lock.sv
module splk_sector_lock #(
  parameter int SECTORS = splk_pkg::SECTORS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic protection_lock_bit,
  output logic [1:0] soft_protect_summary,
  output logic hardware_lock_active
);

  localparam int SW = $clog2(SECTORS);

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_OUT,
    ST_SKIP
  } splk_phase_t;

  function automatic logic [1:0] splk_summary(input logic [SECTORS-1:0] v);
    splk_summary = (&v) ? splk_pkg::SUMMARY_ALL :
                   (|v) ? splk_pkg::SUMMARY_SOME : splk_pkg::SUMMARY_NONE;
  endfunction : splk_summary

  // ---------------- link side, clocked by sck ----------------
  // frame logic is cleared by chip select high, so it never relies on
  // an sck edge after the frame ends
  logic frame_rst_n;
  assign frame_rst_n = resetn & ~cs_n;

  splk_phase_t phase;
  splk_phase_t next_phase;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [6:0] shift;
  logic [7:0] opcode;
  logic [SW-1:0] sector_sel;
  logic [SECTORS-1:0] prot_meta;
  logic [SECTORS-1:0] prot_s;
  // held on the system side, declared here because the link side reads it
  logic [SECTORS-1:0] prot;

  logic [7:0] next_byte;
  logic byte_done;
  logic addr_op;
  logic fire_wsr;
  logic fire_sect;
  logic cap_sector;

  assign next_byte = {shift, si};
  assign byte_done = bit_cnt == splk_pkg::LAST_BIT;
  assign addr_op = next_byte == splk_pkg::OP_READ_PROT ||
                   next_byte == splk_pkg::OP_PROTECT ||
                   next_byte == splk_pkg::OP_UNPROTECT;
  assign cap_sector = phase == ST_ADDR && byte_done &&
                      byte_cnt == splk_pkg::SECTOR_BYTE;
  assign fire_wsr = phase == ST_DATA && byte_done;
  assign fire_sect = phase == ST_ADDR && byte_done &&
                     byte_cnt == splk_pkg::LAST_ADDR_BYTE &&
                     opcode != splk_pkg::OP_READ_PROT;

  always_comb begin
    next_phase = phase;
    case (phase)
      ST_OPCODE: begin
        if (byte_done) begin
          if (addr_op) begin
            next_phase = ST_ADDR;
          end else if (next_byte == splk_pkg::OP_WRITE_STATUS) begin
            next_phase = ST_DATA;
          end else begin
            next_phase = ST_SKIP;
          end
        end
      end
      ST_ADDR: begin
        if (byte_done && byte_cnt == splk_pkg::LAST_ADDR_BYTE) begin
          next_phase = (opcode == splk_pkg::OP_READ_PROT) ?
                       ST_OUT : ST_SKIP;
        end
      end
      ST_DATA: begin
        if (byte_done) begin
          next_phase = ST_SKIP;
        end
      end
      ST_OUT: next_phase = ST_OUT;
      ST_SKIP: next_phase = ST_SKIP;
      default: next_phase = ST_SKIP;
    endcase
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase <= ST_OPCODE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      shift <= 7'h0;
    end else begin
      phase <= next_phase;
      bit_cnt <= 3'(bit_cnt + 3'h1);
      // counts address bytes only, so the opcode byte does not shift it
      byte_cnt <= (phase == ST_ADDR && byte_done) ?
                  2'(byte_cnt + 2'h1) : byte_cnt;
      shift <= next_byte[6:0];
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      opcode <= 8'h00;
      sector_sel <= '0;
    end else begin
      if (phase == ST_OPCODE && byte_done) begin
        opcode <= next_byte;
      end
      if (cap_sector) begin
        sector_sel <= next_byte[SW-1:0];
      end
    end
  end

  // protection bits change rarely; each bit is synchronised on its own,
  // which is safe since a read looks at just one of them
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      prot_meta <= {SECTORS{splk_pkg::PROT_RST}};
      prot_s <= {SECTORS{splk_pkg::PROT_RST}};
    end else begin
      prot_meta <= prot;
      prot_s <= prot_meta;
    end
  end

  // output changes on the falling edge so it is settled for the host
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_oe <= 1'b0;
      so <= 1'b0;
    end else begin
      so_oe <= phase == ST_OUT;
      so <= phase == ST_OUT && prot_s[sector_sel];
    end
  end

  // command hold registers survive the end of the frame; the host needs
  // many sck edges before the next command, far longer than the crossing
  logic cmd_tgl;
  logic [7:0] cmd_op;
  logic [7:0] cmd_data;
  logic [SW-1:0] cmd_sector;

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      cmd_tgl <= 1'b0;
      cmd_op <= 8'h00;
      cmd_data <= 8'h00;
      cmd_sector <= '0;
    end else if (fire_wsr || fire_sect) begin
      cmd_tgl <= ~cmd_tgl;
      cmd_op <= fire_wsr ? splk_pkg::OP_WRITE_STATUS : opcode;
      cmd_data <= fire_wsr ? next_byte : cmd_data;
      cmd_sector <= fire_wsr ? cmd_sector : sector_sel;
    end
  end

  // ---------------- system side, clocked by clk_sys ----------------
  logic wp_meta;
  logic wp_s;
  logic tgl_meta;
  logic tgl_s;
  logic tgl_seen;
  logic lock;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_meta <= splk_pkg::WP_RST;
      wp_s <= splk_pkg::WP_RST;
      tgl_meta <= 1'b0;
      tgl_s <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      wp_meta <= wp_n;
      wp_s <= wp_meta;
      tgl_meta <= cmd_tgl;
      tgl_s <= tgl_meta;
      tgl_seen <= tgl_s;
    end
  end

  logic cmd_evt;
  logic hw_lock;
  logic is_wsr;
  logic is_sect;
  logic do_global;
  logic sect_ok;
  logic set_val;
  logic [3:0] gfield;
  logic next_lock;
  logic [SECTORS-1:0] next_prot;

  assign cmd_evt = tgl_s ^ tgl_seen;
  assign hw_lock = ~wp_s & lock;
  assign is_wsr = cmd_evt && cmd_op == splk_pkg::OP_WRITE_STATUS;
  assign is_sect = cmd_evt && (cmd_op == splk_pkg::OP_PROTECT ||
                               cmd_op == splk_pkg::OP_UNPROTECT);
  assign gfield = cmd_data[splk_pkg::GLOBAL_HI:splk_pkg::GLOBAL_LO];
  // global decode uses the lock value before the write: a write that
  // clears the lock is still soft-locked, one that sets it is not
  assign do_global = is_wsr && !lock;
  assign sect_ok = is_sect && !lock;
  assign set_val = cmd_op == splk_pkg::OP_PROTECT;
  // hardware lock ignores the write; otherwise only bit 7 is stored
  assign next_lock = (is_wsr && !hw_lock) ?
                     cmd_data[splk_pkg::LOCK_POS] : lock;

  genvar gi;
  generate
    for (gi = 0; gi < SECTORS; gi++) begin : g_prot
      assign next_prot[gi] =
        (do_global && gfield == splk_pkg::GLOBAL_SET) ? 1'b1 :
        (do_global && gfield == splk_pkg::GLOBAL_CLEAR) ? 1'b0 :
        (sect_ok && cmd_sector == SW'(gi)) ? set_val : prot[gi];
    end
  endgenerate

  // only resetn (power-up) clears the lock; nothing else can if the pin
  // is tied low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock <= splk_pkg::LOCK_RST;
      prot <= {SECTORS{splk_pkg::PROT_RST}};
      soft_protect_summary <= splk_pkg::SUMMARY_NONE;
      hardware_lock_active <= 1'b0;
    end else begin
      lock <= next_lock;
      prot <= next_prot;
      soft_protect_summary <= splk_summary(prot);
      hardware_lock_active <= hw_lock;
    end
  end

  assign protection_lock_bit = lock;

  // ---------------- checks ----------------
  property p_hw_lock_cause;
    @(posedge clk_sys) disable iff (!resetn)
      hardware_lock_active == ($past(!wp_s) && $past(lock));
  endproperty
  a_hw_lock_cause: assert property (p_hw_lock_cause)
    else $error("hardware lock flag not equal to pin and lock");

  property p_hw_freeze;
    @(posedge clk_sys) disable iff (!resetn)
      (cmd_evt && !wp_s && lock) |=> ($stable(prot) && lock);
  endproperty
  a_hw_freeze: assert property (p_hw_freeze)
    else $error("state changed under hardware lock");

  property p_sector_refused;
    @(posedge clk_sys) disable iff (!resetn)
      (is_sect && lock) |=> $stable(prot);
  endproperty
  a_sector_refused: assert property (p_sector_refused)
    else $error("sector command acted while locked");

  property p_global_set;
    @(posedge clk_sys) disable iff (!resetn)
      (is_wsr && !lock && gfield == splk_pkg::GLOBAL_SET)
        |=> (&prot) ##1 (soft_protect_summary == splk_pkg::SUMMARY_ALL);
  endproperty
  a_global_set: assert property (p_global_set)
    else $error("global protect did not set all sectors");

  property p_global_clear;
    @(posedge clk_sys) disable iff (!resetn)
      (is_wsr && !lock && gfield == splk_pkg::GLOBAL_CLEAR)
        |=> (prot == '0) && lock == $past(cmd_data[splk_pkg::LOCK_POS]);
  endproperty
  a_global_clear: assert property (p_global_clear)
    else $error("global unprotect or lock store wrong");

  property p_unlock_only;
    @(posedge clk_sys) disable iff (!resetn)
      (is_wsr && lock && wp_s && !cmd_data[splk_pkg::LOCK_POS])
        |=> (!lock && $stable(prot));
  endproperty
  a_unlock_only: assert property (p_unlock_only)
    else $error("lock clear failed or touched protection");

  property p_read_starts;
    @(posedge sck) disable iff (!frame_rst_n)
      (phase == ST_ADDR && byte_done && opcode == splk_pkg::OP_READ_PROT &&
       byte_cnt == splk_pkg::LAST_ADDR_BYTE) |=> phase == ST_OUT ##1 so_oe;
  endproperty
  a_read_starts: assert property (p_read_starts)
    else $error("read output did not start after address");

  property p_read_value;
    @(posedge sck) disable iff (!frame_rst_n)
      (so_oe && $stable(prot_s)) |-> so == prot_s[sector_sel];
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("read data does not match protection bit");

endmodule : splk_sector_lock

//--- dv/splk_host.sv
module splk_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // mode 0: link clock idles low, stands still between frames except during reset
  task automatic start;
    cs_n = 1'b0;
    #24;
  endtask : start
  task automatic shift(input int n, input logic [7:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      si = tx[7-i];
      #24 sck = 1'b1;
      rx = {rx[6:0], so};
      #24 sck = 1'b0;
    end
  endtask : shift
  task automatic stop;
    #24 cs_n = 1'b1;
    si = ~si; // released line must not keep a stale value
    #1;
  endtask : stop
  // link flops reset without edges; pulse them with select high
  task automatic idle_clk;
    repeat (2) begin
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask : idle_clk
endmodule : splk_host

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, wp_n, sck, cs_n, si, so, so_oe;
  logic protection_lock_bit, hardware_lock_active, lock;
  logic [1:0] soft_protect_summary;
  logic [31:0] prot;
  logic [7:0] b0, b1;
  int failures, checked, cycles, s;

  splk_sector_lock splk_sector_lock_i (.clk_sys(clk_sys), .resetn(resetn),
    .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .protection_lock_bit(protection_lock_bit),
    .soft_protect_summary(soft_protect_summary),
    .hardware_lock_active(hardware_lock_active));
  splk_host splk_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] f_byte(input logic p);
    return p ? 8'hff : 8'h00;
  endfunction : f_byte
  function automatic logic [1:0] f_sum(input logic [31:0] p);
    if (&p) return splk_pkg::SUMMARY_ALL;
    if (|p) return splk_pkg::SUMMARY_SOME;
    return splk_pkg::SUMMARY_NONE;
  endfunction : f_sum

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      report_and_stop;
    end
  end

  task automatic st;
    repeat (6) @(negedge clk_sys);
    chk({7'h00, protection_lock_bit}, {7'h00, lock});
    chk({6'h00, soft_protect_summary}, {6'h00, f_sum(prot)});
    chk({7'h00, hardware_lock_active}, {7'h00, ~wp_n & lock});
  endtask : st
  task automatic do_reset;
    resetn = 1'b0;
    fork
      splk_host_i.idle_clk;
      repeat (16) @(negedge clk_sys);
    join
    resetn = 1'b1;
    prot = '1;
    lock = splk_pkg::LOCK_RST;
    st;
  endtask : do_reset
  task automatic set_wp(input logic v);
    @(negedge clk_sys);
    wp_n = v;
    st;
  endtask : set_wp
  task automatic wsr(input logic [7:0] d);
    splk_host_i.start;
    splk_host_i.shift(8, splk_pkg::OP_WRITE_STATUS, b0);
    splk_host_i.shift(8, d, b0);
    splk_host_i.stop;
    if (wp_n || !lock) begin
      if (!lock && d[5:2] == splk_pkg::GLOBAL_SET) prot = '1;
      if (!lock && d[5:2] == splk_pkg::GLOBAL_CLEAR) prot = '0;
      lock = d[7];
    end
    st;
  endtask : wsr
  task automatic sec(input logic [7:0] op, input int k);
    splk_host_i.start;
    splk_host_i.shift(8, op, b0);
    splk_host_i.shift(8, {3'($urandom), k[4:0]}, b0);
    splk_host_i.shift(8, 8'($urandom), b0);
    splk_host_i.shift(8, 8'($urandom), b0);
    splk_host_i.stop;
    if (!lock) prot[k] = (op == splk_pkg::OP_PROTECT);
    st;
  endtask : sec
  task automatic rd(input int k, input int n);
    splk_host_i.start;
    splk_host_i.shift(8, splk_pkg::OP_READ_PROT, b0);
    splk_host_i.shift(8, {3'($urandom), k[4:0]}, b0);
    splk_host_i.shift(8, 8'($urandom), b0);
    splk_host_i.shift(8, 8'($urandom), b0);
    splk_host_i.shift(8, 8'h00, b0);
    splk_host_i.shift(n, 8'h00, b1);
    chk({7'h00, so_oe}, 8'h01);
    if (n == 8) chk(b0, f_byte(prot[k]));
    if (n == 8) chk(b1, f_byte(prot[k]));
    splk_host_i.stop;
    chk({6'h00, so_oe, so}, 8'h00);
  endtask : rd

  initial begin
    resetn = 1'b0;
    wp_n = splk_pkg::WP_RST;
    void'($urandom(32'h95f3));
    s = $urandom_range(31, 0);
    do_reset;
    rd(s, 8);
    $display("test reset readout done");
    wsr(8'h00);
    rd(s, 8);
    sec(splk_pkg::OP_PROTECT, s);
    rd(s, 8);
    rd((s + 1) % 32, 8);
    rd(s, 3);
    rd(s, 8);
    $display("test sector protect done");
    wsr(8'hf0);
    set_wp(1'b0);
    rd(s, 8);
    sec(splk_pkg::OP_UNPROTECT, s);
    wsr(8'h00);
    set_wp(1'b1);
    sec(splk_pkg::OP_UNPROTECT, s);
    wsr(8'h3c);
    rd(s, 8);
    wsr(8'hff);
    $display("test locking done");
    set_wp(1'b0);
    do_reset;
    repeat (6) wsr({1'b0, 7'($urandom)});
    wsr(8'h7f);
    sec(splk_pkg::OP_UNPROTECT, s);
    rd(s, 8);
    $display("test pin low unlocked done");
    report_and_stop;
  end
endmodule : testbench
